// file: sysclk_ctrl_sva.sv
// Purpose: port-level checks of the clock and mode controller
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound to the controller at the foot of this file
`default_nettype none

module sysclk_ctrl_sva
   import sysclk_pkg::*;
(
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic [15:0] cpu_addr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata_q,
   input wire logic        rom_sel_q,
   input wire logic        ram_sel_q,
   input wire mstate_e     mstate_q,
   input wire logic        mcycle_end_q,
   input wire logic        instr_done_q,
   input wire logic        irq_req,
   input wire logic        interrupt_master_enable,
   input wire op_mode_e    mode_q,
   input wire gate_s       gate_q,
   input wire logic        irq_accept_q,
   input wire logic        time_base_irq_latch_q,
   input wire logic        time_base_irq_service_q
);
   // ==========================================================
   // assertions
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   a_rom_decode: assert property (
      $past(reset_n) |-> rom_sel_q == ($past(cpu_addr) >= ROM_FIRST))
      else $error("rom select wrong");
   a_ram_decode: assert property (
      $past(reset_n) |-> ram_sel_q == ($past(cpu_addr) inside {[RAM_FIRST:RAM_LAST]}))
      else $error("ram select wrong");
   a_state_step: assert property (
      $past(reset_n) && $past(mode_q) == MODE_NORMAL
      |-> mstate_q == mstate_e'($past(mstate_q) + 2'h1))
      else $error("machine state did not advance");
   a_cycle_end: assert property (
      mcycle_end_q |-> $past(mstate_q) == ST_THREE)
      else $error("cycle end out of place");
   a_done_end: assert property (
      instr_done_q |-> mcycle_end_q)
      else $error("done without cycle end");
   a_cpu_gate: assert property (
      $past(reset_n) |-> gate_q.cpu_run == (mode_q == MODE_NORMAL))
      else $error("cpu clock gate wrong");
   a_osc_gate: assert property (
      $past(reset_n) |-> gate_q.osc_on == (mode_q != MODE_STOP))
      else $error("oscillator gate wrong");
   a_full_idle_gate: assert property (
      mode_q == MODE_FULL_IDLE |-> gate_q.tbt_run && !gate_q.periph_run)
      else $error("full idle gates wrong");
   a_idle_exit: assert property (
      mode_q == MODE_CPU_IDLE && irq_req |=> mode_q == MODE_NORMAL
      && irq_accept_q == $past(interrupt_master_enable))
      else $error("cpu idle exit wrong");
   a_idle_hold: assert property (
      mode_q == MODE_CPU_IDLE && !irq_req |=> mode_q == MODE_CPU_IDLE)
      else $error("cpu idle left without request");
   a_service_cause: assert property (
      time_base_irq_service_q |-> time_base_irq_latch_q && $past(interrupt_master_enable))
      else $error("service without its enables");
   a_rdata_idle: assert property (
      $past(reset_n) && !$past(reg_rd) |-> reg_rdata_q == 8'h00)
      else $error("read data outside read slot");
   a_stop_wake: assert property (
      mode_q == MODE_STOP |=> mode_q inside {MODE_STOP, MODE_WARMUP})
      else $error("stop left without warm-up");

   c_stop_wake: cover property (mode_q == MODE_STOP ##1 mode_q == MODE_WARMUP);
   c_accept: cover property (irq_accept_q);
   c_service: cover property (time_base_irq_service_q);
   c_done: cover property (instr_done_q);
endmodule

bind system_clock_mode_controller sysclk_ctrl_sva u_sva (
   .clk(clk), .reset_n(reset_n), .cpu_addr(cpu_addr), .reg_rd(reg_rd),
   .reg_rdata_q(reg_rdata_q), .rom_sel_q(rom_sel_q), .ram_sel_q(ram_sel_q),
   .mstate_q(mstate_q), .mcycle_end_q(mcycle_end_q), .instr_done_q(instr_done_q),
   .irq_req(irq_req), .interrupt_master_enable(interrupt_master_enable),
   .mode_q(mode_q), .gate_q(gate_q), .irq_accept_q(irq_accept_q),
   .time_base_irq_latch_q(time_base_irq_latch_q),
   .time_base_irq_service_q(time_base_irq_service_q)
);

`default_nettype wire

// file: sysclk_pkg.sv
// Purpose: shared constants and types for the system clock and mode controller
// Assumes: 16-bit address space, 8-bit control registers
// Notes:   warm-up counts are module parameters of the controller
`default_nettype none

package sysclk_pkg;

   // ==========================================================
   // memory map
   localparam logic [15:0] ROM_FIRST = 16'hf800;
   localparam logic [15:0] ROM_LAST  = 16'hffff;
   localparam logic [15:0] RAM_FIRST = 16'h0040;
   localparam logic [15:0] RAM_LAST  = 16'h00bf;
   localparam logic [15:0] SFR_LAST  = 16'h003f;

   // ==========================================================
   // control register offsets
   localparam logic [15:0] TBC_ADDR = 16'h0036;
   localparam logic [15:0] SC1_ADDR = 16'h0038;
   localparam logic [15:0] SC2_ADDR = 16'h0039;

   // ==========================================================
   // field positions and reset values
   localparam int SC1_STOP_BIT  = 7;
   localparam int SC1_STOP_RELEASE_METHOD_BIT  = 6;
   localparam int SC1_OUTEN_BIT = 4;
   localparam int SC1_WUT_LSB   = 2;
   localparam int SC2_XEN_BIT   = 7;
   localparam int SC2_IDLE_BIT  = 4;
   localparam int SC2_HALT_BIT  = 2;
   localparam int TBC_EN_BIT    = 3;
   localparam int TBC_SEL_LSB   = 0;
   localparam logic [7:0] SC1_RST  = 8'h00;
   localparam logic [7:0] SC2_RST  = 8'h80;
   localparam logic [7:0] TBC_RST  = 8'h00;
   localparam logic [7:0] SC1_RMSK = 8'hfc;
   localparam logic [7:0] SC2_RMSK = 8'h94;
   localparam logic [7:0] TBC_RMSK = 8'h0f;

   // ==========================================================
   // timing generator
   localparam int PRESCALE_W = 2;
   localparam int DIVIDER_W  = 21;
   localparam int CHAIN_W    = PRESCALE_W + DIVIDER_W;
   localparam int CLK_PERIOD_NS = 10;
   localparam logic [3:0] MAX_MCYC = 4'ha;
   localparam logic [3:0] MIN_MCYC = 4'h1;
   localparam int unsigned TBT_TAP [0:7] = '{22, 20, 15, 13, 12, 11, 10, 9};

   typedef enum logic [1:0] {
      ST_ZERO,
      ST_ONE,
      ST_TWO,
      ST_THREE
   } mstate_e;

   typedef enum logic [2:0] {
      MODE_NORMAL,
      MODE_CPU_IDLE,
      MODE_FULL_IDLE,
      MODE_STOP,
      MODE_WARMUP
   } op_mode_e;

   typedef struct packed {
      logic cpu_run;
      logic wdt_run;
      logic periph_run;
      logic tbt_run;
      logic osc_on;
      logic port_hold;
   } gate_s;

endpackage

`default_nettype wire

// file: system_clock_mode_controller.sv
// Purpose: clock gating, timing chain, machine cycles and standby modes
// Assumes: clk is the high-frequency clock; cpu strobes are on clk
// Notes:   clk keeps running in stop; osc_on tells the pad to halt
`default_nettype none

// Summary of operation
// RULE_01 - program memory decoded at f800 to ffff
// RULE_02 - data ram decoded at 0040 to 00bf
// RULE_03 - all regions inside one 64k space
// RULE_04 - software should clear ram after power-up
// RULE_05 - 2-stage prescaler plus 21-stage divider chain
// RULE_06 - chain cleared on reset, stop entry, release
// RULE_07 - machine cycle is four one-clock states
// RULE_08 - instructions take one to ten cycles
// RULE_09 - main clock equals fc, cycle four periods
// RULE_10 - reset enters normal run mode
// RULE_11 - idle bit halts cpu and watchdog only
// RULE_12 - any interrupt request ends cpu idle
// RULE_13 - idle exit: service irq or continue
// RULE_14 - halt bit stops all but time base
// RULE_15 - time base falling edge ends full idle
// RULE_16 - full idle ignores time base enable
// RULE_17 - service needs master, individual, timer enables
// RULE_18 - enabled timer sets latch after full idle
// RULE_19 - stop turns oscillator off, holds state
// RULE_20 - stop pin releases, level or edge
// RULE_21 - warm-up then continue after stop instruction
// RULE_22 - external clock drives input pin only
// RULE_23 - release method zero edge, one level
// RULE_24 - warm-up select picks one of four counts
// RULE_25 - idle bit self-clears on idle release
// RULE_26 - software never sets idle and halt together
// RULE_27 - warm-up counted on cleared divider chain
module system_clock_mode_controller
   import sysclk_pkg::*;
#(
   parameter int unsigned WARMUP_CYC_00 = 3 * 65536,
   parameter int unsigned WARMUP_CYC_01 = 65536,
   parameter int unsigned WARMUP_CYC_10 = 3 * 16384,
   parameter int unsigned WARMUP_CYC_11 = 16384
) (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic [15:0] reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output var  logic [7:0]  reg_rdata_q,
   input  wire logic [15:0] cpu_addr,
   output var  logic        rom_sel_q,
   output var  logic        ram_sel_q,
   output var  logic        sfr_sel_q,
   input  wire logic        instr_start,
   input  wire logic [3:0]  instr_cycles,
   output var  mstate_e     mstate_q,
   output var  logic        mcycle_end_q,
   output var  logic        instr_done_q,
   input  wire logic        irq_req,
   input  wire logic        interrupt_master_enable,
   input  wire logic        time_base_irq_enable,
   input  wire logic        stop_release_pin,
   output var  op_mode_e    mode_q,
   output var  gate_s       gate_q,
   output var  logic        irq_accept_q,
   output var  logic        resume_next_q,
   output var  logic        time_base_irq_latch_q,
   output var  logic        time_base_irq_service_q,
   output var  logic        time_base_clk_q
);

   // ==========================================================
   // control registers
   logic [7:0] system_control_one_q;
   logic [7:0] system_control_one_d;
   logic [7:0] system_control_two_q;
   logic [7:0] system_control_two_d;
   logic [7:0] time_base_control_q;
   logic [7:0] time_base_control_d;

   wire wr_sc1 = reg_wr && (reg_addr == SC1_ADDR);
   wire wr_sc2 = reg_wr && (reg_addr == SC2_ADDR);
   wire wr_tbc = reg_wr && (reg_addr == TBC_ADDR);

   wire       stop_release_method = system_control_one_q[SC1_STOP_RELEASE_METHOD_BIT];
   wire [1:0] warmup_select = system_control_one_q[SC1_WUT_LSB +: 2];
   wire       time_base_enable_bit = time_base_control_q[TBC_EN_BIT];
   wire [2:0] time_base_clock_select = time_base_control_q[TBC_SEL_LSB +: 3];

   // ==========================================================
   // register read, data valid only in the cycle after the strobe
   logic [7:0] rd_mux;
   assign rd_mux = (reg_addr == SC1_ADDR) ? (system_control_one_q & SC1_RMSK) :
                   (reg_addr == SC2_ADDR) ? (system_control_two_q & SC2_RMSK) :
                   (reg_addr == TBC_ADDR) ? (time_base_control_q & TBC_RMSK) :
                   8'h00;

   // ==========================================================
   // memory map decode
   logic rom_hit;
   logic ram_hit;
   logic sfr_hit;
   assign rom_hit = (cpu_addr >= ROM_FIRST);                             // [RULE_01] [RULE_03]
   assign ram_hit = (cpu_addr >= RAM_FIRST) && (cpu_addr <= RAM_LAST);   // [RULE_02] [RULE_03]
   assign sfr_hit = (cpu_addr <= SFR_LAST);                              // [RULE_03]

   // ==========================================================
   // stop pin synchroniser and release detect
   logic pin_s1_q;
   logic pin_s2_q;
   logic pin_s3_q;
   logic pin_rise;
   logic release_hit;
   assign pin_rise = pin_s2_q && !pin_s3_q;
   assign release_hit = stop_release_method ? pin_s2_q : pin_rise;       // [RULE_20] [RULE_23]

   // ==========================================================
   // prescaler and divider chain
   logic [CHAIN_W-1:0] chain_q;
   logic [CHAIN_W-1:0] chain_d;
   logic               chain_clr;
   logic               tap_now;
   logic               tap_q;
   logic               tap_fall;
   logic [CHAIN_W-1:0] warm_last;
   logic               warm_done;

   // ==========================================================
   // mode control
   op_mode_e mode_d;
   logic     enter_stop;
   logic     enter_cpu_idle;
   logic     enter_full_idle;
   logic     leave_cpu_idle;
   logic     leave_full_idle;
   logic     leave_stop;
   logic     entered_tbt_en_q;

   assign enter_stop = (mode_q == MODE_NORMAL) && wr_sc1 && reg_wdata[SC1_STOP_BIT];
   // idle wins if software breaks the one-bit-at-a-time convention
   assign enter_cpu_idle = (mode_q == MODE_NORMAL) && !enter_stop && wr_sc2 &&
                           reg_wdata[SC2_IDLE_BIT];                         // [RULE_11] [RULE_26]
   assign enter_full_idle = (mode_q == MODE_NORMAL) && !enter_stop && wr_sc2 &&
                            !reg_wdata[SC2_IDLE_BIT] &&
                            reg_wdata[SC2_HALT_BIT];                        // [RULE_14] [RULE_16]
   assign leave_cpu_idle = (mode_q == MODE_CPU_IDLE) && irq_req;           // [RULE_12]
   assign leave_full_idle = (mode_q == MODE_FULL_IDLE) && tap_fall;        // [RULE_15] [RULE_16]
   assign leave_stop = (mode_q == MODE_STOP) && release_hit;               // [RULE_20]

   always_comb begin
      mode_d = mode_q;
      unique case (mode_q)
         MODE_NORMAL: begin
            if (enter_stop) begin
               mode_d = MODE_STOP;                                         // [RULE_19]
            end else if (enter_cpu_idle) begin
               mode_d = MODE_CPU_IDLE;
            end else if (enter_full_idle) begin
               mode_d = MODE_FULL_IDLE;
            end
         end
         MODE_CPU_IDLE: begin
            if (leave_cpu_idle) begin
               mode_d = MODE_NORMAL;
            end
         end
         MODE_FULL_IDLE: begin
            if (leave_full_idle) begin
               mode_d = MODE_NORMAL;
            end
         end
         MODE_STOP: begin
            if (leave_stop) begin
               mode_d = MODE_WARMUP;
            end
         end
         MODE_WARMUP: begin
            if (warm_done) begin
               mode_d = MODE_NORMAL;                                       // [RULE_21]
            end
         end
         default: mode_d = MODE_NORMAL;
      endcase
   end

   // chain counts fc from reset; frozen while the oscillator is off
   assign chain_clr = enter_stop || leave_stop;                            // [RULE_06]
   assign chain_d = chain_clr ? '0 :
                    (mode_q == MODE_STOP) ? chain_q :
                    chain_q + {{(CHAIN_W-1){1'b0}}, 1'b1};                  // [RULE_05] [RULE_19]
   assign tap_now = chain_q[TBT_TAP[time_base_clock_select]];
   assign tap_fall = tap_q && !tap_now;

   // warm-up runs on the freshly cleared chain
   always_comb begin
      unique case (warmup_select)
         2'b00:   warm_last = CHAIN_W'(WARMUP_CYC_00 - 1);                 // [RULE_24]
         2'b01:   warm_last = CHAIN_W'(WARMUP_CYC_01 - 1);
         2'b10:   warm_last = CHAIN_W'(WARMUP_CYC_10 - 1);
         2'b11:   warm_last = CHAIN_W'(WARMUP_CYC_11 - 1);
      endcase
   end
   assign warm_done = (mode_q == MODE_WARMUP) && (chain_q == warm_last);   // [RULE_27]

   // ==========================================================
   // register next values; hardware clears only in states where
   // the cpu is halted, so no software write can collide
   always_comb begin
      system_control_one_d = system_control_one_q;
      system_control_two_d = system_control_two_q;
      time_base_control_d  = time_base_control_q;
      if (wr_sc1) begin
         system_control_one_d = reg_wdata;
      end
      if (wr_sc2) begin
         system_control_two_d = reg_wdata;
      end
      if (wr_tbc) begin
         time_base_control_d = reg_wdata;
      end
      if (warm_done) begin
         system_control_one_d[SC1_STOP_BIT] = 1'b0;
      end
      if (leave_cpu_idle) begin
         system_control_two_d[SC2_IDLE_BIT] = 1'b0;                        // [RULE_25]
      end
      if (leave_full_idle) begin
         system_control_two_d[SC2_HALT_BIT] = 1'b0;
      end
   end

   // ==========================================================
   // machine cycle sequencer
   logic       cpu_run;
   logic [3:0] cyc_left_q;
   logic [3:0] cyc_load;
   logic       last_state;
   assign cpu_run = (mode_q == MODE_NORMAL);
   assign last_state = cpu_run && (mstate_q == ST_THREE);
   assign cyc_load = (instr_cycles < MIN_MCYC) ? MIN_MCYC :
                     (instr_cycles > MAX_MCYC) ? MAX_MCYC : instr_cycles;  // [RULE_08]

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mstate_q     <= ST_ZERO;
         mcycle_end_q <= 1'b0;
         instr_done_q <= 1'b0;
         cyc_left_q   <= 4'h0;
      end else begin
         if (cpu_run) begin
            mstate_q <= mstate_e'(mstate_q + 2'h1);                        // [RULE_07] [RULE_09]
         end
         mcycle_end_q <= last_state;
         instr_done_q <= last_state && (cyc_left_q == 4'h1);
         if (cpu_run && instr_start && (mstate_q == ST_ZERO)) begin
            cyc_left_q <= cyc_load;                                        // [RULE_08]
         end else if (last_state && (cyc_left_q != 4'h0)) begin
            cyc_left_q <= cyc_left_q - 4'h1;
         end
      end
   end

   // ==========================================================
   // time base events
   logic tbt_tick;
   logic tbt_set;
   assign tbt_tick = tap_fall && time_base_enable_bit &&
                     ((mode_q == MODE_NORMAL) || (mode_q == MODE_CPU_IDLE));
   assign tbt_set = tbt_tick || (leave_full_idle && entered_tbt_en_q);    // [RULE_18]

   // ==========================================================
   // state registers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         system_control_one_q <= SC1_RST;
         system_control_two_q <= SC2_RST;
         time_base_control_q  <= TBC_RST;
         mode_q               <= MODE_NORMAL;                              // [RULE_10]
         chain_q              <= '0;                                       // [RULE_06]
         tap_q                <= 1'b0;
         entered_tbt_en_q     <= 1'b0;
         pin_s1_q             <= 1'b0;
         pin_s2_q             <= 1'b0;
         pin_s3_q             <= 1'b0;
      end else begin
         system_control_one_q <= system_control_one_d;
         system_control_two_q <= system_control_two_d;
         time_base_control_q  <= time_base_control_d;
         mode_q               <= mode_d;
         chain_q              <= chain_d;
         tap_q                <= tap_now;
         pin_s1_q             <= stop_release_pin;
         pin_s2_q             <= pin_s1_q;
         pin_s3_q             <= pin_s2_q;
         if (enter_full_idle) begin
            entered_tbt_en_q <= time_base_enable_bit;
         end
      end
   end

   // ==========================================================
   // registered outputs
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata_q             <= 8'h00;
         rom_sel_q               <= 1'b0;
         ram_sel_q               <= 1'b0;
         sfr_sel_q               <= 1'b0;
         gate_q                  <= '0;
         irq_accept_q            <= 1'b0;
         resume_next_q           <= 1'b0;
         time_base_irq_latch_q   <= 1'b0;
         time_base_irq_service_q <= 1'b0;
         time_base_clk_q         <= 1'b0;
      end else begin
         reg_rdata_q <= reg_rd ? rd_mux : 8'h00;
         rom_sel_q   <= rom_hit;
         ram_sel_q   <= ram_hit;
         sfr_sel_q   <= sfr_hit;
         gate_q.cpu_run    <= (mode_d == MODE_NORMAL);                     // [RULE_11]
         gate_q.wdt_run    <= (mode_d == MODE_NORMAL);
         gate_q.periph_run <= (mode_d == MODE_NORMAL) ||
                              (mode_d == MODE_CPU_IDLE);                   // [RULE_14]
         gate_q.tbt_run    <= (mode_d != MODE_STOP) && (mode_d != MODE_WARMUP);
         gate_q.osc_on     <= (mode_d != MODE_STOP);                       // [RULE_19]
         gate_q.port_hold  <= system_control_one_q[SC1_OUTEN_BIT];
         irq_accept_q  <= leave_cpu_idle && interrupt_master_enable;       // [RULE_13]
         resume_next_q <= (leave_cpu_idle && !interrupt_master_enable) ||
                          warm_done;                                       // [RULE_13] [RULE_21]
         time_base_irq_latch_q   <= tbt_set;
         time_base_irq_service_q <= tbt_set && interrupt_master_enable &&
                                    time_base_irq_enable &&
                                    time_base_enable_bit;                  // [RULE_17]
         time_base_clk_q <= tap_now;
      end
   end

endmodule

`default_nettype wire

// file: test_system_clock_mode_controller.sv
// Purpose: directed bench for the clock and mode controller
// Assumes: short warm-up counts 12/4/8/2
// Notes:   every scenario judges its own results
`default_nettype none

module test_system_clock_mode_controller
   import sysclk_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk, reset_n, reg_wr, reg_rd, instr_start, irq_req, ime, tb_irq_en, stop_pin;
   logic [15:0] reg_addr, cpu_addr;
   logic [7:0]  reg_wdata, reg_rdata_q;
   logic [3:0]  instr_cycles;
   logic        rom_sel_q, ram_sel_q, sfr_sel_q, mcycle_end_q, instr_done_q;
   logic        irq_accept_q, resume_next_q, tb_latch, tb_service, time_base_clk_q;
   mstate_e     mstate_q;
   op_mode_e    mode_q;
   gate_s       gate_q;
   int          miscompares = 0;
   int          check_count = 0;
   logic [15:0] dec_a [8] = '{16'hf800, 16'hffff, 16'hf7ff, 16'h0040,
                              16'h00bf, 16'h00c0, 16'h003f, 16'h0000};
   logic [2:0]  dec_s [8] = '{3'h4, 3'h4, 3'h0, 3'h2, 3'h2, 3'h0, 3'h1, 3'h1};

   system_clock_mode_controller #(.WARMUP_CYC_00(12), .WARMUP_CYC_01(4),
      .WARMUP_CYC_10(8), .WARMUP_CYC_11(2)) DUT (
      .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .cpu_addr(cpu_addr),
      .rom_sel_q(rom_sel_q), .ram_sel_q(ram_sel_q), .sfr_sel_q(sfr_sel_q),
      .instr_start(instr_start), .instr_cycles(instr_cycles), .mstate_q(mstate_q),
      .mcycle_end_q(mcycle_end_q), .instr_done_q(instr_done_q), .irq_req(irq_req),
      .interrupt_master_enable(ime), .time_base_irq_enable(tb_irq_en),
      .stop_release_pin(stop_pin), .mode_q(mode_q), .gate_q(gate_q),
      .irq_accept_q(irq_accept_q), .resume_next_q(resume_next_q),
      .time_base_irq_latch_q(tb_latch), .time_base_irq_service_q(tb_service),
      .time_base_clk_q(time_base_clk_q));

   // ==========================================================
   // shared tasks
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata_q, e, "read data");
   endtask

   task automatic wait_mode(input op_mode_e m, input int lim, output int n);
      #1;
      for (n = 0; n < lim && mode_q !== m; n++) begin
         @(posedge clk);
         #1;
      end
   endtask

   // ==========================================================
   // scenarios
   task automatic t_regs();
      rd(SC1_ADDR, SC1_RST);
      rd(SC2_ADDR, SC2_RST);
      rd(TBC_ADDR, TBC_RST);
      wr(TBC_ADDR, 8'hff);
      rd(TBC_ADDR, TBC_RMSK);
      wr(16'h0037, 8'hff);
      rd(16'h0037, 8'h00);
      wr(TBC_ADDR, 8'h00);
      #1;
      chk(mode_q, MODE_NORMAL, "mode after reset");
   endtask

   task automatic t_decode();
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         cpu_addr <= dec_a[i];
         repeat (2) @(posedge clk);
         #1;
         chk({rom_sel_q, ram_sel_q, sfr_sel_q}, dec_s[i], "decode");
      end
   endtask

   task automatic t_instr(input logic [3:0] n);
      int k;
      int c0;
      int ends;
      ends = 0;
      c0 = 0;
      @(posedge clk);
      #1;
      while (mstate_q !== ST_THREE) begin
         @(posedge clk);
         #1;
      end
      @(posedge clk);
      instr_start <= 1'b1;
      instr_cycles <= n;
      @(posedge clk);
      instr_start <= 1'b0;
      #1;
      for (k = 1; k < 60 && instr_done_q !== 1'b1; k++) begin
         @(posedge clk);
         #1;
         if (mcycle_end_q === 1'b1) begin
            ends++;
            if (ends == 1) c0 = k;
         end
      end
      chk(ends, n, "machine cycles");
      chk(k - 1 - c0, 4 * (n - 1), "states per cycle");
   endtask

   task automatic t_cpu_idle(input logic ie);
      int n;
      @(posedge clk);
      ime <= ie;
      wr(SC2_ADDR, 8'h90);
      wait_mode(MODE_CPU_IDLE, 3, n);
      repeat (5) @(posedge clk);
      #1;
      chk(mode_q, MODE_CPU_IDLE, "idle entry");
      chk({gate_q.cpu_run, gate_q.wdt_run, gate_q.periph_run, gate_q.osc_on}, 4'h3,
          "idle gates");
      @(posedge clk);
      irq_req <= 1'b1;
      @(posedge clk);
      irq_req <= 1'b0;
      #1;
      chk(mode_q, MODE_NORMAL, "idle exit");
      chk({irq_accept_q, resume_next_q}, {ie, ~ie}, "idle resume");
      rd(SC2_ADDR, 8'h80);
   endtask

   task automatic t_full_idle(input logic en, input logic ie);
      int n;
      logic lat;
      logic svc;
      lat = 1'b0;
      svc = 1'b0;
      @(posedge clk);
      ime <= ie;
      tb_irq_en <= 1'b1;
      wr(TBC_ADDR, {4'h0, en, 3'h7});
      wr(SC2_ADDR, 8'h84);
      wait_mode(MODE_FULL_IDLE, 3, n);
      chk({gate_q.cpu_run, gate_q.periph_run, gate_q.tbt_run}, 3'h1, "full idle");
      wait_mode(MODE_NORMAL, 1100, n);
      chk(mode_q, MODE_NORMAL, "full idle wake");
      for (n = 0; n < 5; n++) begin
         lat = lat | tb_latch;
         svc = svc | tb_service;
         @(posedge clk);
         #1;
      end
      chk(lat, en, "latch after wake");
      chk(svc, en & ie, "service after wake");
      rd(SC2_ADDR, 8'h80);
      wr(TBC_ADDR, 8'h00);
   endtask

   task automatic t_stop(input logic rl, input logic [1:0] wu, input int cyc);
      int n;
      @(posedge clk);
      stop_pin <= ~rl;
      repeat (4) @(posedge clk);
      wr(SC1_ADDR, {1'b1, rl, 2'h0, wu, 2'h0});
      wait_mode(MODE_STOP, 3, n);
      repeat (20) @(posedge clk);
      #1;
      chk({mode_q, gate_q.osc_on, gate_q.port_hold, time_base_clk_q}, {MODE_STOP, 3'h0},
          "stop hold");
      if (!rl) begin
         @(posedge clk);
         stop_pin <= 1'b0;
         repeat (4) @(posedge clk);
         #1;
         chk(mode_q, MODE_STOP, "falling pin");
      end
      @(posedge clk);
      stop_pin <= 1'b1;
      wait_mode(MODE_WARMUP, 8, n);
      for (n = 0; n < 40 && mode_q === MODE_WARMUP; n++) begin
         @(posedge clk);
         #1;
      end
      chk(n, cyc, "warm-up length");
      chk({mode_q, resume_next_q}, {MODE_NORMAL, 1'b1}, "stop resume");
      @(posedge clk);
      stop_pin <= 1'b0;
      rd(SC1_ADDR, {1'b0, rl, 2'h0, wu, 2'h0});
   endtask

   // ==========================================================
   // main sequence
   initial begin
      {reset_n, reg_wr, reg_rd, instr_start, irq_req, ime, tb_irq_en, stop_pin} = '0;
      reg_addr = 16'h0000;
      cpu_addr = 16'h0000;
      reg_wdata = 8'h00;
      instr_cycles = 4'h1;
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      t_regs();
      t_decode();
      t_instr(4'h1);
      t_instr(4'h2);
      t_instr(4'ha);
      t_cpu_idle(1'b1);
      t_cpu_idle(1'b0);
      t_full_idle(1'b1, 1'b1);
      t_full_idle(1'b0, 1'b1);
      t_full_idle(1'b1, 1'b0);
      t_stop(1'b1, 2'h3, 2);
      t_stop(1'b0, 2'h0, 12);
      t_stop(1'b1, 2'h1, 4);
      t_stop(1'b0, 2'h2, 8);
      tally_and_finish();
   end

   // the run needs some 3300 cycles; this leaves ample margin
   initial begin
      #200us;
      miscompares++;
      $display("mismatch at %0t: watchdog expired", $time);
      tally_and_finish();
   end
endmodule

`default_nettype wire
